/* File: src/rcr_pkg.sv */
// Purpose: Shared constants and types for the regulator configuration register pair
// Assumes: 8-bit register port driven by a target-side serial protocol engine
// Notes: Register images travel as packed structs laid out MSB first

package rcr_pkg;

    // Register offsets on the byte register port
    localparam logic [7:0] CFG_A_OFFSET = 8'h02;
    localparam logic [7:0] CFG_B_OFFSET = 8'h03;

    // Reset images of both registers
    localparam logic [7:0] CFG_A_RESET = 8'hce;
    localparam logic [7:0] CFG_B_RESET = 8'h71;

    // Writable bits of the second register; bits 7 and 3 are reserved
    localparam logic [7:0] CFG_B_WRITE_MASK = 8'h77;

    // Value returned for any offset this bank does not own
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Field positions, first register
    localparam int ILIM_MSB = 7;
    localparam int ILIM_LSB = 6;
    localparam int RISE_SLEW_BIT = 5;
    localparam int FALL_SLEW_BIT = 4;
    localparam int OVP_TH_MSB = 3;
    localparam int OVP_TH_LSB = 2;
    localparam int DISCHARGE_BIT = 1;
    localparam int FPWM_BIT = 0;

    // Field positions, second register
    localparam int OUT_EN_BIT = 6;
    localparam int EN_PULLDOWN_BIT = 5;
    localparam int PGOOD_POL_BIT = 4;
    localparam int PIN_FUNC_MSB = 2;
    localparam int PIN_FUNC_LSB = 0;

    // Overvoltage threshold code that turns protection off
    localparam logic [1:0] OVP_TH_OFF = 2'h0;

    // Multifunction pin roles; other codes are storable but select no role
    typedef enum logic [2:0] {
        RCR_PIN_FPWM  = 3'b001,
        RCR_PIN_ILIM  = 3'b010,
        RCR_PIN_VSEL  = 3'b011,
        RCR_PIN_PGOOD = 3'b100,
        RCR_PIN_IRQ   = 3'b101
    } rcr_pin_func_e;

    // First configuration register image
    typedef struct packed {
        logic [1:0] peak_current_limit_sel;
        logic       rise_slew_sel;
        logic       fall_slew_sel;
        logic [1:0] overvoltage_threshold_sel;
        logic       output_discharge_enable;
        logic       forced_pwm_select;
    } rcr_cfg_a_s;

    // Second configuration register image
    typedef struct packed {
        logic       rsvd_7;
        logic       output_enable;
        logic       enable_pin_pulldown;
        logic       power_good_polarity;
        logic       rsvd_3;
        logic [2:0] pin_func;
    } rcr_cfg_b_s;

    // Settings actually applied to the power stage after pin overrides
    typedef struct packed {
        logic [1:0] peak_current_limit_sel;
        logic       rise_slew_sel;
        logic       fall_slew_sel;
        logic [1:0] overvoltage_threshold_sel;
        logic       ovp_enable;
        logic       output_discharge_enable;
        logic       forced_pwm_select;
        logic       output_enable;
        logic       enable_pin_pulldown;
        logic       power_good_polarity;
        logic [2:0] pin_func;
        logic       pin_drives_out;
        logic       pin_vout_high;
    } rcr_eff_s;

    // True when the pin role field holds the given role
    function automatic logic pin_is(input logic [2:0] func, input rcr_pin_func_e role);
        pin_is = (func == 3'(role));
    endfunction

endpackage

/* File: src/rcr_pin_override.sv */
// Purpose: Merge register settings with the multifunction pin to form applied settings
// Assumes: Pin level already synchronous to the core clock
// Notes: Purely combinational; the caller registers the result

`timescale 1ns/1ps

module rcr_pin_override #(
    parameter logic [1:0] ILIM_PIN_LOW = 2'h0,   // Limit code applied while the pin is low
    parameter logic [1:0] ILIM_PIN_HIGH = 2'h3   // Limit code applied while the pin is high
) (
    input wire rcr_pkg::rcr_cfg_a_s i_cfg_a,
    input wire rcr_pkg::rcr_cfg_b_s i_cfg_b,
    input wire logic i_pin_level,
    output rcr_pkg::rcr_eff_s o_eff
);

    // Decode the pin role once and steer each overridable field
    always_comb begin
        o_eff = '0;
        o_eff.rise_slew_sel = i_cfg_a.rise_slew_sel;
        o_eff.fall_slew_sel = i_cfg_a.fall_slew_sel;
        o_eff.overvoltage_threshold_sel = i_cfg_a.overvoltage_threshold_sel;
        // Code 00 switches overvoltage protection off
        o_eff.ovp_enable = (i_cfg_a.overvoltage_threshold_sel != rcr_pkg::OVP_TH_OFF);
        o_eff.output_discharge_enable = i_cfg_a.output_discharge_enable;
        o_eff.output_enable = i_cfg_b.output_enable;
        o_eff.enable_pin_pulldown = i_cfg_b.enable_pin_pulldown;
        o_eff.power_good_polarity = i_cfg_b.power_good_polarity;
        o_eff.pin_func = i_cfg_b.pin_func;
        // Peak current limit: pin wins in current-limit role
        if (rcr_pkg::pin_is(i_cfg_b.pin_func, rcr_pkg::RCR_PIN_ILIM)) begin
            o_eff.peak_current_limit_sel = i_pin_level ? ILIM_PIN_HIGH : ILIM_PIN_LOW;
        end else begin
            o_eff.peak_current_limit_sel = i_cfg_a.peak_current_limit_sel;
        end
        // Skip or forced PWM: pin wins in forced-PWM role
        if (rcr_pkg::pin_is(i_cfg_b.pin_func, rcr_pkg::RCR_PIN_FPWM)) begin
            o_eff.forced_pwm_select = i_pin_level;
        end else begin
            o_eff.forced_pwm_select = i_cfg_a.forced_pwm_select;
        end
        // Status roles turn the pin into an output
        o_eff.pin_drives_out = rcr_pkg::pin_is(i_cfg_b.pin_func, rcr_pkg::RCR_PIN_PGOOD)
                             | rcr_pkg::pin_is(i_cfg_b.pin_func, rcr_pkg::RCR_PIN_IRQ);
        // Voltage select role picks the high voltage register while the pin is high
        o_eff.pin_vout_high = rcr_pkg::pin_is(i_cfg_b.pin_func, rcr_pkg::RCR_PIN_VSEL) & i_pin_level;
    end

endmodule

/* File: src/rcr_regulator_config_registers.sv */
// Purpose: Two configuration registers of a buck-boost regulator and their applied settings
// Assumes: A protocol engine presents byte reads and writes on a simple strobe port
// Notes: Read data and pin-driven applied settings lag the cause by one clock edge; register writes reach applied settings two edges later
//
// What this block does
// - Bits 7:6 pick peak current limit, reset 11
// - Pin current-limit role overrides the limit field
// - Bits 5 and 4 pick rise/fall slew, reset 0
// - Bits 3:2 set overvoltage threshold, 00 off
// - Bit 1 enables output discharge, reset 1
// - Bit 0 forced PWM; pin overrides in role 001
// - Second register bit 6 enables output, reset 1
// - Second register bit 5 enables pin pulldown, reset 1
// - Bits 2:0 choose the multifunction pin role
// - Undervoltage or enable low restores both defaults

`timescale 1ns/1ps

module rcr_regulator_config_registers #(
    parameter logic [2:0] PIN_FUNC_DEFAULT = 3'h1,   // Variant-dependent reset pin role
    parameter logic [1:0] ILIM_PIN_LOW = 2'h0,       // Limit code for pin low in current-limit role
    parameter logic [1:0] ILIM_PIN_HIGH = 2'h3       // Limit code for pin high in current-limit role
) (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_supply_uvlo,
    input wire logic i_enable_pin,
    input wire logic i_mfp_level,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic [1:0] o_peak_current_limit_sel,
    output logic o_rise_slew_sel,
    output logic o_fall_slew_sel,
    output logic [1:0] o_overvoltage_threshold_sel,
    output logic o_ovp_enable,
    output logic o_output_discharge_enable,
    output logic o_forced_pwm_select,
    output logic o_output_enable,
    output logic o_enable_pin_pulldown,
    output logic o_power_good_polarity,
    output logic [2:0] o_pin_func,
    output logic o_pin_drives_out,
    output logic o_pin_vout_high
);

    // Reset image of the second register with the variant's pin role spliced in
    localparam logic [7:0] CFG_B_RESET_V = {rcr_pkg::CFG_B_RESET[7:3], PIN_FUNC_DEFAULT};

    // Applied-setting image right after any reset, matching the override logic
    localparam logic PIN_ILIM_AT_RESET = (PIN_FUNC_DEFAULT == 3'(rcr_pkg::RCR_PIN_ILIM));
    localparam logic PIN_FPWM_AT_RESET = (PIN_FUNC_DEFAULT == 3'(rcr_pkg::RCR_PIN_FPWM));
    localparam logic PIN_OUT_AT_RESET = (PIN_FUNC_DEFAULT == 3'(rcr_pkg::RCR_PIN_PGOOD))
                                      | (PIN_FUNC_DEFAULT == 3'(rcr_pkg::RCR_PIN_IRQ));

    // Register state
    rcr_pkg::rcr_cfg_a_s cfg_a_reg;   // First configuration register
    rcr_pkg::rcr_cfg_b_s cfg_b_reg;   // Second configuration register
    rcr_pkg::rcr_eff_s eff_reg;       // Applied settings, one flop per output
    logic [7:0] rdata_reg;            // Read data holding flop
    logic rvalid_reg;                 // Read answer strobe

    // Combinational intermediates
    rcr_pkg::rcr_eff_s eff_next;      // Applied settings from the override stage
    logic [7:0] rdata_next;           // Read mux result
    logic defaults_hold;              // Any condition that forces default values
    logic hit_a;                      // Access targets the first register
    logic hit_b;                      // Access targets the second register

    // Default-forcing condition; kept as a level so defaults persist while it stands
    assign defaults_hold = i_srst | i_supply_uvlo | ~i_enable_pin;

    // Address decode shared by the write and read paths
    assign hit_a = (i_reg_addr == rcr_pkg::CFG_A_OFFSET);
    assign hit_b = (i_reg_addr == rcr_pkg::CFG_B_OFFSET);

    // First register: load on write, defaults while held
    // Writes during a hold are dropped, since the part is not powered up for them
    always_ff @(posedge i_core_clk) begin
        if (defaults_hold) begin
            cfg_a_reg <= rcr_pkg::rcr_cfg_a_s'(rcr_pkg::CFG_A_RESET);
        end else if (i_reg_wr && hit_a) begin
            // Every bit of this register is writable
            cfg_a_reg <= rcr_pkg::rcr_cfg_a_s'(i_reg_wdata);
        end
    end

    // Second register: load on write with reserved bits forced to zero
    always_ff @(posedge i_core_clk) begin
        if (defaults_hold) begin
            cfg_b_reg <= rcr_pkg::rcr_cfg_b_s'(CFG_B_RESET_V);
        end else if (i_reg_wr && hit_b) begin
            // Masking keeps reserved storage at zero so reads see zero too
            cfg_b_reg <= rcr_pkg::rcr_cfg_b_s'(i_reg_wdata & rcr_pkg::CFG_B_WRITE_MASK);
        end
    end

    // Override stage: the pin takes over fields in some roles
    rcr_pin_override #(
        .ILIM_PIN_LOW(ILIM_PIN_LOW),
        .ILIM_PIN_HIGH(ILIM_PIN_HIGH)
    ) u_pin_override (
        .i_cfg_a(cfg_a_reg),
        .i_cfg_b(cfg_b_reg),
        .i_pin_level(i_mfp_level),
        .o_eff(eff_next)
    );

    // Applied settings flop; outputs come straight from it
    // Costs one cycle of latency but keeps glitches off the power stage controls
    always_ff @(posedge i_core_clk) begin
        if (defaults_hold) begin
            eff_reg.peak_current_limit_sel <= PIN_ILIM_AT_RESET ? ILIM_PIN_LOW :
                                              rcr_pkg::CFG_A_RESET[rcr_pkg::ILIM_MSB:rcr_pkg::ILIM_LSB];
            eff_reg.rise_slew_sel <= rcr_pkg::CFG_A_RESET[rcr_pkg::RISE_SLEW_BIT];
            eff_reg.fall_slew_sel <= rcr_pkg::CFG_A_RESET[rcr_pkg::FALL_SLEW_BIT];
            eff_reg.overvoltage_threshold_sel <= rcr_pkg::CFG_A_RESET[rcr_pkg::OVP_TH_MSB:rcr_pkg::OVP_TH_LSB];
            eff_reg.ovp_enable <= (rcr_pkg::CFG_A_RESET[rcr_pkg::OVP_TH_MSB:rcr_pkg::OVP_TH_LSB]
                                   != rcr_pkg::OVP_TH_OFF);
            eff_reg.output_discharge_enable <= rcr_pkg::CFG_A_RESET[rcr_pkg::DISCHARGE_BIT];
            // Pin level is not a constant, so the pin-driven mode starts in skip
            eff_reg.forced_pwm_select <= PIN_FPWM_AT_RESET ? 1'b0 : rcr_pkg::CFG_A_RESET[rcr_pkg::FPWM_BIT];
            eff_reg.output_enable <= CFG_B_RESET_V[rcr_pkg::OUT_EN_BIT];
            eff_reg.enable_pin_pulldown <= CFG_B_RESET_V[rcr_pkg::EN_PULLDOWN_BIT];
            eff_reg.power_good_polarity <= CFG_B_RESET_V[rcr_pkg::PGOOD_POL_BIT];
            eff_reg.pin_func <= CFG_B_RESET_V[rcr_pkg::PIN_FUNC_MSB:rcr_pkg::PIN_FUNC_LSB];
            eff_reg.pin_drives_out <= PIN_OUT_AT_RESET;
            eff_reg.pin_vout_high <= 1'b0;
        end else begin
            // Live path through the override stage
            eff_reg <= eff_next;
        end
    end

    // Read mux; unowned offsets answer a fixed value
    always_comb begin
        if (hit_a) begin
            rdata_next = 8'(cfg_a_reg);
        end else if (hit_b) begin
            // Stored reserved bits are zero; mask again so reads stay zero regardless
            rdata_next = 8'(cfg_b_reg) & rcr_pkg::CFG_B_WRITE_MASK;
        end else begin
            rdata_next = rcr_pkg::UNMAPPED_READ;
        end
    end

    // Read answer: data captured on the request edge, strobe for one cycle
    // Data holds until the next read so a slow engine may sample it late
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= i_reg_rd;
            if (i_reg_rd) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // Output assignments from flops
    assign o_reg_rdata = rdata_reg;
    assign o_reg_rvalid = rvalid_reg;
    assign o_peak_current_limit_sel = eff_reg.peak_current_limit_sel;
    assign o_rise_slew_sel = eff_reg.rise_slew_sel;
    assign o_fall_slew_sel = eff_reg.fall_slew_sel;
    assign o_overvoltage_threshold_sel = eff_reg.overvoltage_threshold_sel;
    assign o_ovp_enable = eff_reg.ovp_enable;
    assign o_output_discharge_enable = eff_reg.output_discharge_enable;
    assign o_forced_pwm_select = eff_reg.forced_pwm_select;
    assign o_output_enable = eff_reg.output_enable;
    assign o_enable_pin_pulldown = eff_reg.enable_pin_pulldown;
    assign o_power_good_polarity = eff_reg.power_good_polarity;
    assign o_pin_func = eff_reg.pin_func;
    assign o_pin_drives_out = eff_reg.pin_drives_out;
    assign o_pin_vout_high = eff_reg.pin_vout_high;

endmodule

/* File: test/rcr_cfg_properties.sv */
// Purpose: Port-level temporal checks for the regulator configuration registers
// Assumes: Hold means supply undervoltage high or enable pin low
// Notes: Applied outputs lag a register write by two edges, the pin by one, as the pin feeds the output flop directly
`timescale 1ns/1ps
module rcr_cfg_properties #(
    parameter logic [2:0] PIN_FUNC_DEFAULT = 3'h1, // Reset pin role
    parameter logic [1:0] ILIM_PIN_LOW = 2'h0, // Limit code for pin low
    parameter logic [1:0] ILIM_PIN_HIGH = 2'h3 // Limit code for pin high
) (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_supply_uvlo,
    input wire logic i_enable_pin,
    input wire logic i_mfp_level,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic [1:0] o_peak_current_limit_sel,
    input wire logic o_rise_slew_sel,
    input wire logic o_fall_slew_sel,
    input wire logic [1:0] o_overvoltage_threshold_sel,
    input wire logic o_ovp_enable,
    input wire logic o_output_discharge_enable,
    input wire logic o_forced_pwm_select,
    input wire logic o_output_enable,
    input wire logic o_enable_pin_pulldown,
    input wire logic o_power_good_polarity,
    input wire logic [2:0] o_pin_func,
    input wire logic o_pin_drives_out,
    input wire logic o_pin_vout_high
);
    // Either hold condition forces defaults
    wire logic hold = i_supply_uvlo || !i_enable_pin;
    // Limit code applied at reset depends on the default pin role
    localparam logic [1:0] ILIM_DEF = (PIN_FUNC_DEFAULT == 3'h2) ? ILIM_PIN_LOW : 2'h3;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    // A write followed by a quiet cycle, so only it shapes the outputs
    sequence s_quiet_wr(logic [7:0] a);
        i_reg_wr && i_reg_addr == a && !hold ##1 !hold && !i_reg_wr;
    endsequence
    // Pin role steady long enough for the pin to reach the outputs
    sequence s_role(logic [2:0] r);
        (o_pin_func == r && !hold) [*3];
    endsequence
    a_hold_defaults: assert property (hold ##1 hold |=> o_peak_current_limit_sel == ILIM_DEF
        && {o_rise_slew_sel, o_fall_slew_sel, o_overvoltage_threshold_sel} == 4'h3 && o_output_discharge_enable
        && o_output_enable && o_enable_pin_pulldown && o_power_good_polarity && o_pin_func == PIN_FUNC_DEFAULT)
        else $error("Applied settings not at defaults under hold");
    a_write_first_reg: assert property (s_quiet_wr(8'h02) |=> {o_rise_slew_sel, o_fall_slew_sel,
        o_overvoltage_threshold_sel, o_output_discharge_enable} == $past(i_reg_wdata[5:1], 2))
        else $error("First register write not applied");
    a_write_second_reg: assert property (s_quiet_wr(8'h03) |=> {o_output_enable, o_enable_pin_pulldown,
        o_power_good_polarity, o_pin_func} == {$past(i_reg_wdata[6:4], 2), $past(i_reg_wdata[2:0], 2)})
        else $error("Second register write not applied");
    a_fpwm_pin_follow: assert property (s_role(3'h1) |-> o_forced_pwm_select == $past(i_mfp_level, 1))
        else $error("Forced PWM does not follow the pin");
    a_ilim_pin_follow: assert property (s_role(3'h2) |->
        o_peak_current_limit_sel == ($past(i_mfp_level, 1) ? ILIM_PIN_HIGH : ILIM_PIN_LOW))
        else $error("Current limit does not follow the pin");
    // Voltage select role: the high voltage choice tracks the pin one edge late
    a_vout_pin_follow: assert property (s_role(3'h3) |-> o_pin_vout_high == $past(i_mfp_level, 1))
        else $error("Voltage select does not follow the pin");
    a_ovp_code_off: assert property (o_ovp_enable == (o_overvoltage_threshold_sel != 2'h0))
        else $error("Overvoltage enable disagrees with threshold code");
    a_pin_drive_role: assert property (o_pin_drives_out == (o_pin_func == 3'h4 || o_pin_func == 3'h5))
        else $error("Pin drive disagrees with pin role");
    a_reserved_read_zero: assert property (i_reg_rd && i_reg_addr == 8'h03 |=>
        o_reg_rvalid && !o_reg_rdata[7] && !o_reg_rdata[3])
        else $error("Reserved bits read nonzero");
endmodule
bind rcr_regulator_config_registers rcr_cfg_properties #(.PIN_FUNC_DEFAULT(PIN_FUNC_DEFAULT),
    .ILIM_PIN_LOW(ILIM_PIN_LOW), .ILIM_PIN_HIGH(ILIM_PIN_HIGH)) u_rcr_cfg_properties (.*);

/* File: test/rcr_host_model.sv */
// Purpose: Host side of the byte register port, issuing single reads and writes
// Assumes: One strobe cycle per byte, read answer one cycle after the request edge
// Notes: Released address and data show the inverse so stale values never match
`timescale 1ns/1ps
module rcr_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    // Idle bus at time zero
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    // One write strobe, then release
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    // One read strobe; answer taken inside its one valid cycle
    task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
        v = i_rvalid;
        d = i_rdata;
    endtask
endmodule

/* File: test/tb_top.sv */
// Purpose: Self-checking bench for the regulator configuration registers
// Assumes: Default parameters, pin role 001 after reset
// Notes: Expected values come from the register layout, never from the outputs
`timescale 1ns/1ps
module tb_top;
    logic i_core_clk, i_srst, i_supply_uvlo, i_enable_pin, i_mfp_level, i_reg_wr, i_reg_rd, o_reg_rvalid;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, d, rd_d;
    logic [1:0] o_peak_current_limit_sel, o_overvoltage_threshold_sel;
    logic o_rise_slew_sel, o_fall_slew_sel, o_ovp_enable, o_output_discharge_enable, o_forced_pwm_select;
    logic o_output_enable, o_enable_pin_pulldown, o_power_good_polarity, o_pin_drives_out, o_pin_vout_high, rd_v;
    logic [2:0] o_pin_func;
    int n_mismatch = 0;
    int samples_checked = 0;
    // Ports share names with the bench signals
    rcr_regulator_config_registers u_rcr_regulator_config_registers (.*);
    rcr_host_model u_rcr_host_model (.i_clk(i_core_clk), .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid),
        .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
    // 100 MHz clock
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=0x%h exp=0x%h", $time, seen, exp);
        end
    endtask
    // Read and compare, also checking the answer pulse
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        u_rcr_host_model.read_byte(a, rd_d, rd_v);
        chk(8'(rd_v), 8'h01);
        chk(rd_d, exp);
    endtask
    // Let outputs settle a fixed number of edges
    task automatic wait_edges(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic results();
        $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Hang guard, far beyond the roughly 130 cycles the tests need
    initial begin
        repeat (5000) @(posedge i_core_clk);
        n_mismatch++;
        results();
    end
    initial begin
        {i_srst, i_supply_uvlo, i_enable_pin, i_mfp_level} = 4'b1010;
        repeat (12) @(posedge i_core_clk);
        i_srst <= 1'b0;
        rd_chk(8'h02, 8'hce);
        rd_chk(8'h03, 8'h71);
        chk({o_peak_current_limit_sel, o_rise_slew_sel, o_fall_slew_sel, o_overvoltage_threshold_sel,
            o_output_discharge_enable, o_forced_pwm_select}, 8'hce);
        chk({1'b0, o_output_enable, o_enable_pin_pulldown, o_power_good_polarity, 1'b0, o_pin_func}, 8'h71);
        $display("test reset values done");
        // Every limit and threshold code; bit 0 stored but pin governs in role 001
        for (int i = 0; i < 4; i++) begin
            d = {i[1:0], i[0], i[1], i[1:0], ~i[0], i[0]};
            u_rcr_host_model.write_byte(8'h02, d);
            wait_edges(1);
            chk({o_peak_current_limit_sel, o_rise_slew_sel, o_fall_slew_sel, o_overvoltage_threshold_sel,
                o_output_discharge_enable, o_forced_pwm_select}, {d[7:1], 1'b0});
            chk(8'(o_ovp_enable), 8'(i != 0));
            rd_chk(8'h02, d);
        end
        $display("test first register done");
        u_rcr_host_model.write_byte(8'h03, 8'hff);
        rd_chk(8'h03, 8'h77);
        u_rcr_host_model.write_byte(8'h03, 8'h08);
        rd_chk(8'h03, 8'h00);
        chk(8'({o_output_enable, o_enable_pin_pulldown, o_pin_drives_out}), 8'h00);
        $display("test second register done");
        // Each pin role with both pin levels; register limit 11, forced PWM bit 1
        for (int r = 1; r < 6; r++) begin
            u_rcr_host_model.write_byte(8'h03, 8'(r));
            for (int m = 0; m < 2; m++) begin
                @(posedge i_core_clk);
                i_mfp_level <= m[0];
                wait_edges(3);
                chk(8'(o_pin_drives_out), 8'(r == 4 || r == 5));
                chk(8'(o_pin_func), 8'(r));
                chk(8'(o_peak_current_limit_sel), (r == 2 && m == 0) ? 8'h00 : 8'h03);
                chk(8'(o_forced_pwm_select), (r == 1) ? 8'(m) : 8'h01);
                chk(8'(o_pin_vout_high), 8'(r == 3 && m == 1));
            end
        end
        $display("test pin roles done");
        rd_chk(8'h04, 8'h00);
        u_rcr_host_model.write_byte(8'h04, 8'h00);
        rd_chk(8'h02, 8'hfd);
        $display("test unmapped offset done");
        // Undervoltage, then enable low; writes under hold are dropped
        for (int k = 0; k < 2; k++) begin
            u_rcr_host_model.write_byte(8'h02, 8'h00);
            u_rcr_host_model.write_byte(8'h03, 8'h00);
            @(posedge i_core_clk);
            i_supply_uvlo <= (k == 0);
            i_enable_pin <= (k == 0);
            u_rcr_host_model.write_byte(8'h02, 8'h10);
            wait_edges(2);
            chk(8'({o_peak_current_limit_sel, o_rise_slew_sel, o_fall_slew_sel, o_overvoltage_threshold_sel,
                o_output_discharge_enable}), 8'h67);
            @(posedge i_core_clk);
            i_supply_uvlo <= 1'b0;
            i_enable_pin <= 1'b1;
            rd_chk(8'h02, 8'hce);
            rd_chk(8'h03, 8'h71);
        end
        $display("test hold defaults done");
        results();
    end
endmodule
